// *** hw/jbi_fifo.v ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module jbi_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fill side
  input wire inValid,
  input wire [W-1:0] inData,
  output wire inReady,
  // Drain side
  output wire outValid,
  output wire [W-1:0] outData,
  input wire outReady
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire doPush;
  wire doPop;

  assign inReady = (count != D[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData = mem[rdPtr];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  always @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPop) begin
        rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPush & ~doPop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (doPop & ~doPush) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/jbi_map.vh ***
/*
  Constants of the boundary-scan port and its configuration interlock.
  Assumes inclusion by bare name from the design files under hw/.
*/
`ifndef JBI_MAP_VH
`define JBI_MAP_VH

// Instruction register
`define JBI_IR_W 10
`define JBI_IR_CAPTURE 10'h001
`define JBI_OP_BYPASS 10'h3ff
`define JBI_OP_EXTEST 10'h00f
`define JBI_OP_SAMPLE 10'h005
`define JBI_OP_IDCODE 10'h006
`define JBI_OP_USERDATA 10'h00c
`define JBI_OP_HIGHZ 10'h00b
`define JBI_OP_CFG_INTERRUPT 10'h00d
`define JBI_OP_PULSE_CONFIG 10'h001
`define JBI_OP_PRIV0 10'h310
`define JBI_OP_PRIV1 10'h0c9
`define JBI_OP_PRIV2 10'h313
`define JBI_OP_PRIV3 10'h317

// Data registers
`define JBI_PINS 4
`define JBI_BSR_W 12
`define JBI_USER_W 8
`define JBI_FIFO_DEPTH 8
`define JBI_FIFO_AW 3
// Arbitrary identification value, LSB fixed at one
`define JBI_IDCODE 32'h0a5c3001

// Pin synchroniser: {pinIn, configRequestN, trstN, tdi, tms, tck}
`define JBI_SYNC_W 9
`define JBI_SYNC_RST 9'h01e

`endif

// *** hw/jbi_tap.v ***
/*
  Boundary-scan test access port with configuration interlock, pin
  boundary cells and a user data register feeding a FIFO.
  Assumes all test pins and pads are asynchronous to clk and change
  slowly against it (TCK well below clk/6); the configuration engine
  runs on clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "jbi_map.vh"

module jbi_tap (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Test port pins
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trstN,
  output reg tdo,
  output reg tdoOeN,
  // Configuration pins and engine
  input wire configRequestN,
  input wire cfgActive,
  input wire cfgDone,
  output reg cfgAbort,
  output reg cfgRestart,
  output reg cfgHold,
  // Chip-wide functional controls
  input wire chipClearN,
  input wire chipOutputEnable,
  // Core side of the pins
  input wire [3:0] coreOut,
  input wire [3:0] coreOe,
  input wire [3:0] pinOutputOnly,
  // Pads
  input wire [3:0] pinIn,
  output reg [3:0] pinOut,
  output reg [3:0] pinOeN,
  output reg [3:0] inBufEn,
  // User data stream
  output reg [7:0] usrData,
  output reg usrValid,
  input wire usrReady
);
  localparam [3:0] TLR = 4'h0;
  localparam [3:0] RTI = 4'h1;
  localparam [3:0] SELDR = 4'h2;
  localparam [3:0] CAPDR = 4'h3;
  localparam [3:0] SHDR = 4'h4;
  localparam [3:0] EX1DR = 4'h5;
  localparam [3:0] PDR = 4'h6;
  localparam [3:0] EX2DR = 4'h7;
  localparam [3:0] UPDR = 4'h8;
  localparam [3:0] SELIR = 4'h9;
  localparam [3:0] CAPIR = 4'ha;
  localparam [3:0] SHIR = 4'hb;
  localparam [3:0] EX1IR = 4'hc;
  localparam [3:0] PIR = 4'hd;
  localparam [3:0] EX2IR = 4'he;
  localparam [3:0] UPIR = 4'hf;

  reg [`JBI_SYNC_W-1:0] syncA;
  reg [`JBI_SYNC_W-1:0] syncB;
  reg [`JBI_SYNC_W-1:0] syncC;
  reg [`JBI_SYNC_W-1:0] stable;
  reg tckPrev;
  reg reqPrev;
  reg [3:0] tap;
  reg [3:0] next_tap;
  reg [`JBI_IR_W-1:0] irShift;
  reg [`JBI_IR_W-1:0] irActive;
  reg [`JBI_IR_W-1:0] next_ir;
  reg bypassReg;
  reg [31:0] idReg;
  reg [`JBI_BSR_W-1:0] bsr;
  reg [3:0] updOut;
  reg [3:0] updOe;
  reg [`JBI_USER_W-1:0] userReg;
  reg [`JBI_USER_W-1:0] pendWord;
  reg pending;
  reg interrupted;
  reg drTdo;
  wire tckS;
  wire tmsS;
  wire tdiS;
  wire trstS;
  wire reqS;
  wire [3:0] padS;
  wire tckRise;
  wire tckFall;
  wire fifoReady;
  wire fifoValid;
  wire [7:0] fifoData;
  wire fifoPop;
  wire cellDrive;
  wire highz;
  wire sampling;
  integer i;
  integer j;

  // Maps a shifted code to the instruction that really takes effect
  function [`JBI_IR_W-1:0] effectiveOp;
    input [`JBI_IR_W-1:0] op;
    input cfgBusy;
    begin
      effectiveOp = op;
      // Reserved codes are neutralised rather than trusted
      if (op == `JBI_OP_PRIV0 || op == `JBI_OP_PRIV1 ||
          op == `JBI_OP_PRIV2 || op == `JBI_OP_PRIV3) begin
        effectiveOp = `JBI_OP_BYPASS;
      end else if (cfgBusy && op != `JBI_OP_BYPASS &&
          op != `JBI_OP_IDCODE && op != `JBI_OP_SAMPLE &&
          op != `JBI_OP_CFG_INTERRUPT) begin
        // Other tests wait for an interrupt
        effectiveOp = `JBI_OP_BYPASS;
      end
    end
  endfunction

  assign tckS = stable[0];
  assign tmsS = stable[1];
  assign tdiS = stable[2];
  assign trstS = stable[3];
  assign reqS = stable[4];
  assign padS = stable[8:5];
  assign tckRise = tckS & ~tckPrev;
  assign tckFall = ~tckS & tckPrev;
  assign cellDrive = (irActive == `JBI_OP_EXTEST) ||
                     (irActive == `JBI_OP_CFG_INTERRUPT);
  assign highz = (irActive == `JBI_OP_HIGHZ);
  assign sampling = (irActive == `JBI_OP_SAMPLE);
  assign fifoPop = fifoValid & (~usrValid | usrReady);

  // Three-stage pin sampling; a change counts once stages two and three agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA <= `JBI_SYNC_RST;
      syncB <= `JBI_SYNC_RST;
      syncC <= `JBI_SYNC_RST;
      stable <= `JBI_SYNC_RST;
      tckPrev <= 1'b0;
      reqPrev <= 1'b1;
    end else begin
      syncA <= {pinIn, configRequestN, trstN, tdi, tms, tck};
      syncB <= syncA;
      syncC <= syncB;
      if (syncB == syncC) begin
        stable <= syncC;
      end
      tckPrev <= tckS;
      reqPrev <= reqS;
    end
  end

  always @* begin
    next_tap = tap;
    case (tap)
      TLR: next_tap = tmsS ? TLR : RTI;
      RTI: next_tap = tmsS ? SELDR : RTI;
      SELDR: next_tap = tmsS ? SELIR : CAPDR;
      CAPDR: next_tap = tmsS ? EX1DR : SHDR;
      SHDR: next_tap = tmsS ? EX1DR : SHDR;
      EX1DR: next_tap = tmsS ? UPDR : PDR;
      PDR: next_tap = tmsS ? EX2DR : PDR;
      EX2DR: next_tap = tmsS ? UPDR : SHDR;
      UPDR: next_tap = tmsS ? SELDR : RTI;
      SELIR: next_tap = tmsS ? TLR : CAPIR;
      CAPIR: next_tap = tmsS ? EX1IR : SHIR;
      SHIR: next_tap = tmsS ? EX1IR : SHIR;
      EX1IR: next_tap = tmsS ? UPIR : PIR;
      PIR: next_tap = tmsS ? EX2IR : PIR;
      EX2IR: next_tap = tmsS ? UPIR : SHIR;
      UPIR: next_tap = tmsS ? SELDR : RTI;
      default: next_tap = TLR;
    endcase
  end

  always @* begin
    next_ir = effectiveOp(irShift, cfgActive & ~interrupted);
  end

  always @* begin
    case (irActive)
      `JBI_OP_BYPASS: drTdo = bypassReg;
      `JBI_OP_IDCODE: drTdo = idReg[0];
      `JBI_OP_EXTEST: drTdo = bsr[0];
      `JBI_OP_SAMPLE: drTdo = bsr[0];
      `JBI_OP_CFG_INTERRUPT: drTdo = bsr[0];
      `JBI_OP_USERDATA: drTdo = userReg[0];
      default: drTdo = bypassReg;
    endcase
  end

  // Controller runs from reset with no enable chip clear
  // and chip output enable reach this logic only through pinOut and pinOeN captured into bsr
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tap <= TLR;
      irShift <= `JBI_IR_CAPTURE;
      irActive <= `JBI_OP_IDCODE;
      bypassReg <= 1'b0;
      idReg <= `JBI_IDCODE;
      bsr <= {`JBI_BSR_W{1'b0}};
      updOut <= 4'h0;
      updOe <= 4'hf;
      userReg <= {`JBI_USER_W{1'b0}};
      pendWord <= {`JBI_USER_W{1'b0}};
      pending <= 1'b0;
      interrupted <= 1'b0;
      cfgAbort <= 1'b0;
      cfgRestart <= 1'b0;
      cfgHold <= 1'b0;
      tdo <= 1'b1;
      tdoOeN <= 1'b1;
    end else begin
      cfgRestart <= 1'b0;
      // Low request pin keeps configuration from starting
      cfgHold <= ~reqS;
      if (pending & fifoReady) begin
        pending <= 1'b0;
      end
      if (~trstS) begin
        tap <= TLR;
        irActive <= `JBI_OP_IDCODE;
        tdoOeN <= 1'b1;
      end else if (tckRise) begin
        tap <= next_tap;
        if (next_tap == TLR) begin
          irActive <= `JBI_OP_IDCODE;
        end
        case (tap)
          CAPIR: irShift <= `JBI_IR_CAPTURE;
          SHIR: irShift <= {tdiS, irShift[`JBI_IR_W-1:1]};
          CAPDR: begin
            bypassReg <= 1'b0;
            idReg <= `JBI_IDCODE;
            for (i = 0; i < `JBI_PINS; i = i + 1) begin
              bsr[3*i] <= padS[i];
              bsr[3*i+1] <= pinOeN[i];
              bsr[3*i+2] <= pinOut[i];
            end
            // Busy flags let the tester see back-pressure
            userReg <= {{(`JBI_USER_W-2){1'b0}}, ~fifoReady, pending};
          end
          SHDR: begin
            bypassReg <= tdiS;
            idReg <= {tdiS, idReg[31:1]};
            bsr <= {tdiS, bsr[`JBI_BSR_W-1:1]};
            userReg <= {tdiS, userReg[`JBI_USER_W-1:1]};
          end
          default: begin
          end
        endcase
      end else if (tckFall) begin
        // TDO changes on the falling edge, driven only while shifting
        if (tap == SHIR) begin
          tdo <= irShift[0];
          tdoOeN <= 1'b0;
        end else if (tap == SHDR) begin
          tdo <= drTdo;
          tdoOeN <= 1'b0;
        end else begin
          tdoOeN <= 1'b1;
        end
        if (tap == UPIR) begin
          irActive <= next_ir;
          if (next_ir == `JBI_OP_CFG_INTERRUPT) begin
            interrupted <= 1'b1;
            cfgAbort <= 1'b1;
          end
          if (next_ir == `JBI_OP_PULSE_CONFIG && interrupted) begin
            interrupted <= 1'b0;
            cfgAbort <= 1'b0;
            cfgRestart <= 1'b1;
          end
        end
        if (tap == UPDR) begin
          if (irActive == `JBI_OP_EXTEST || irActive == `JBI_OP_SAMPLE ||
              irActive == `JBI_OP_CFG_INTERRUPT) begin
            for (i = 0; i < `JBI_PINS; i = i + 1) begin
              updOe[i] <= bsr[3*i+1];
              updOut[i] <= bsr[3*i+2];
            end
          end
          // A word arriving while one still waits is dropped
          if (irActive == `JBI_OP_USERDATA && ~pending) begin
            pendWord <= userReg;
            pending <= 1'b1;
          end
        end
      end
      // Released request pin after a low pulse restarts too
      if (reqS & ~reqPrev) begin
        interrupted <= 1'b0;
        cfgAbort <= 1'b0;
        cfgRestart <= 1'b1;
      end
    end
  end

  // Pad drivers and input buffers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut <= 4'h0;
      pinOeN <= 4'hf;
      inBufEn <= 4'hf;
    end else begin
      for (j = 0; j < `JBI_PINS; j = j + 1) begin
        if (highz) begin
          pinOeN[j] <= 1'b1;
          pinOut[j] <= 1'b0;
        end else if (cellDrive) begin
          // Zero in the enable cell drives the data cell
          pinOeN[j] <= updOe[j];
          pinOut[j] <= updOut[j];
        end else begin
          // Chip-wide controls act on the functional path only
          pinOeN[j] <= ~(coreOe[j] & chipOutputEnable);
          pinOut[j] <= coreOut[j] & chipClearN;
        end
        // Sampling opens buffers of output-only pins
        inBufEn[j] <= ~cfgDone | ~pinOutputOnly[j] | sampling;
      end
    end
  end

  // Output stage keeps the stream outputs on flip-flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      usrValid <= 1'b0;
      usrData <= 8'h00;
    end else begin
      if (fifoPop) begin
        usrValid <= 1'b1;
        usrData <= fifoData;
      end else if (usrReady) begin
        usrValid <= 1'b0;
      end
    end
  end

  jbi_fifo #(
    .W(`JBI_USER_W),
    .D(`JBI_FIFO_DEPTH),
    .AW(`JBI_FIFO_AW)
  ) uFifo (
    .clk(clk),
    .rst(rst),
    .inValid(pending),
    .inData(pendWord),
    .inReady(fifoReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(fifoPop)
  );
endmodule
`default_nettype wire

// *** test/jbi_tap_checker.sv ***
/* Assertions on the test port, interlock and pad buffer outputs.
   Assumes binding to jbi_tap; pins change slowly against clk. */
`timescale 1ns/100ps
`default_nettype none
module jbi_tap_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Test port
  input wire logic tck,
  input wire logic trstN,
  input wire logic tdo,
  input wire logic tdoOeN,
  // Configuration
  input wire logic configRequestN,
  input wire logic cfgDone,
  input wire logic cfgAbort,
  input wire logic cfgRestart,
  input wire logic cfgHold,
  // Chip controls and pads
  input wire logic chipClearN,
  input wire logic chipOutputEnable,
  input wire logic [3:0] pinOutputOnly,
  input wire logic [3:0] inBufEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_reqLow;
    !configRequestN [*4];
  endsequence
  sequence s_reqRelease;
    s_reqLow ##1 configRequestN;
  endsequence
  property p_pinRestart;
    s_reqRelease |-> ##[1:8] cfgRestart;
  endproperty
  property p_restartPulse;
    cfgRestart |=> !cfgRestart;
  endproperty
  property p_restartClears;
    cfgRestart |-> ##[0:1] !cfgAbort;
  endproperty
  property p_abortFall;
    $fell(cfgAbort) |-> cfgRestart || $past(cfgRestart);
  endproperty
  property p_hold;
    $stable(configRequestN) [*8] |-> cfgHold == !configRequestN;
  endproperty
  property p_inBuf;
    1'b1 |=> (inBufEn | ($past(pinOutputOnly) & {4{$past(cfgDone)}}))
      == 4'hf;
  endproperty
  // Sync delay puts TDO moves about five samples after a TCK fall
  property p_tdoEdge;
    $changed(tdo) || $changed(tdoOeN) |-> !$past(tck, 5);
  endproperty
  property p_trst;
    !trstN [*6] |-> tdoOeN;
  endproperty
  property p_chipIndep;
    $changed(chipClearN) || $changed(chipOutputEnable)
      |=> $stable(cfgAbort) && !cfgRestart;
  endproperty
  a_pinRestart: assert property (p_pinRestart)
    else $error("no restart after request pulse");
  a_restartPulse: assert property (p_restartPulse)
    else $error("restart longer than one cycle");
  a_restartClears: assert property (p_restartClears)
    else $error("abort kept after restart");
  a_abortFall: assert property (p_abortFall)
    else $error("abort dropped without restart");
  a_hold: assert property (p_hold)
    else $error("hold does not follow request pin");
  a_inBuf: assert property (p_inBuf)
    else $error("input buffer off where it must be on");
  a_tdoEdge: assert property (p_tdoEdge)
    else $error("tdo moved outside tck low phase");
  a_trst: assert property (p_trst)
    else $error("tdo driven during test reset");
  a_chipIndep: assert property (p_chipIndep)
    else $error("chip control disturbed configuration");
endmodule
bind jbi_tap jbi_tap_checker chk (.clk(clk), .rst(rst), .tck(tck),
  .trstN(trstN), .tdo(tdo), .tdoOeN(tdoOeN),
  .configRequestN(configRequestN), .cfgDone(cfgDone),
  .cfgAbort(cfgAbort), .cfgRestart(cfgRestart), .cfgHold(cfgHold),
  .chipClearN(chipClearN), .chipOutputEnable(chipOutputEnable),
  .pinOutputOnly(pinOutputOnly), .inBufEn(inBufEn));
`default_nettype wire

// *** test/jbi_tester.sv ***
/* Tester model driving TCK, TMS and TDI and reading TDO.
   Assumes calls at a falling clk edge; TCK period is 8 clk. */
`timescale 1ns/100ps
`default_nettype none
module jbi_tester (
  // Clock
  input wire logic clk,
  // Test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // TCK idles low; TDI rests at its pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // TDO read at the end of the high half, well after its fall update
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    tck = 1'b0;
    repeat (4) @(negedge clk);
    tck = 1'b1;
    repeat (4) @(negedge clk);
    o = tdo;
  endtask
  // Parks TCK low once the last rise has been taken
  task automatic park();
    tck = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic toReset();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    park();
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic o;
    logic [4:0] path;
    path = ir ? 5'b00110 : 5'b00001;
    dout = 32'h0;
    for (int i = 0; i < (ir ? 5 : 3); i++) step(path[i], 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    park();
  endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
/* Bench: tester model on TCK, TMS, TDI and TDO, bench on trstN,
   configuration, pads and user stream. Assumes the constants of jbi_map.vh. */
`timescale 1ns/100ps
`default_nettype none
`include "jbi_map.vh"
module tb;
  logic clk, rst, tck, tms, tdi, trstN, tdo, tdoOeN, cfgHold;
  logic configRequestN, cfgActive, cfgDone, cfgAbort, cfgRestart;
  logic chipClearN, chipOutputEnable, usrValid, usrReady;
  logic [3:0] coreOut, coreOe, pinOutputOnly, pinIn, pinOut, pinOeN;
  logic [3:0] inBufEn;
  logic [7:0] usrData;
  logic [31:0] q;
  int errCount = 0, checksDone = 0, restarts = 0, cycles = 0;
  jbi_tap dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trstN(trstN), .tdo(tdo), .tdoOeN(tdoOeN),
    .configRequestN(configRequestN), .cfgActive(cfgActive),
    .cfgDone(cfgDone), .cfgAbort(cfgAbort), .cfgRestart(cfgRestart),
    .cfgHold(cfgHold), .chipClearN(chipClearN),
    .chipOutputEnable(chipOutputEnable), .coreOut(coreOut),
    .coreOe(coreOe), .pinOutputOnly(pinOutputOnly), .pinIn(pinIn),
    .pinOut(pinOut), .pinOeN(pinOeN), .inBufEn(inBufEn),
    .usrData(usrData), .usrValid(usrValid), .usrReady(usrReady));
  jbi_tester ts (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cfgRestart === 1'b1) restarts <= restarts + 1;
    if (cycles == 30000) begin
      errCount++;
      results();
    end
  end
  task automatic results();
    if (errCount == 0 && checksDone > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ir(input logic [9:0] op);
    ts.scan(1'b1, 10, {22'h0, op}, q);
    check(q[9:0], `JBI_IR_CAPTURE);
  endtask
  task automatic dr(input int n, input logic [31:0] d);
    ts.scan(1'b0, n, d, q);
  endtask
  task automatic t_idcode();
    cfgActive = 1'b1;
    ts.toReset();
    ir(`JBI_OP_IDCODE);
    dr(32, 32'h0);
    check(q, `JBI_IDCODE);
    check(cfgAbort, 1'b0);
  endtask
  task automatic t_bypass();
    logic [9:0] codes [7] = '{`JBI_OP_BYPASS, `JBI_OP_PRIV0, `JBI_OP_PRIV1,
      `JBI_OP_PRIV2, `JBI_OP_PRIV3, `JBI_OP_EXTEST, `JBI_OP_USERDATA};
    foreach (codes[i]) begin
      ir(codes[i]);
      dr(4, 32'hb);
      check(q[3:0], 4'h6);
      check(cfgAbort, 1'b0);
    end
  endtask
  task automatic t_config();
    int r;
    r = restarts;
    coreOe = 4'hf;
    coreOut = 4'hf;
    ir(`JBI_OP_CFG_INTERRUPT);
    check(cfgAbort, 1'b1);
    check({pinOeN, pinOut}, 8'hf0);
    trstN = 1'b0;
    waitc(8);
    trstN = 1'b1;
    waitc(6);
    check({tdoOeN, cfgAbort}, 2'b11);
    ir(`JBI_OP_PULSE_CONFIG);
    check(restarts - r, 1);
    check(cfgAbort, 1'b0);
    ir(`JBI_OP_CFG_INTERRUPT);
    configRequestN = 1'b0;
    waitc(10);
    check(cfgHold, 1'b1);
    configRequestN = 1'b1;
    waitc(10);
    check(restarts - r, 2);
    check({cfgHold, cfgAbort}, 2'b00);
  endtask
  task automatic t_extest();
    int r;
    r = restarts;
    cfgActive = 1'b0;
    configRequestN = 1'b0;
    pinIn = 4'h9;
    ir(`JBI_OP_SAMPLE);
    dr(12, 32'h120);
    check({q[9], q[6], q[3], q[0]}, pinIn);
    ir(`JBI_OP_EXTEST);
    check({pinOeN, pinOut}, 8'h06);
    chipClearN = 1'b0;
    chipOutputEnable = 1'b0;
    waitc(4);
    check({pinOeN, pinOut}, 8'h06);
    chipClearN = 1'b1;
    chipOutputEnable = 1'b1;
    ir(`JBI_OP_HIGHZ);
    check({pinOeN, pinOut}, 8'hf0);
    configRequestN = 1'b1;
    waitc(10);
    check(restarts - r, 1);
  endtask
  task automatic t_inbuf();
    cfgDone = 1'b1;
    pinOutputOnly = 4'ha;
    ir(`JBI_OP_IDCODE);
    check(inBufEn, 4'h5);
    ir(`JBI_OP_SAMPLE);
    check(inBufEn, 4'hf);
  endtask
  // Fill while stalled until words drop, then drain with a stalling sink
  task automatic t_stream();
    int n;
    n = 0;
    ir(`JBI_OP_USERDATA);
    for (int k = 0; k < 12; k++) begin
      dr(8, 32'h40 + k);
      if (k == 0) check(q[1:0], 2'b00);
    end
    check(q[1:0], 2'b11);
    repeat (200) begin
      @(negedge clk);
      usrReady = ~usrReady;
      if (usrValid === 1'b1 && usrReady) begin
        check(usrData, 8'h40 + n[7:0]);
        n++;
      end
    end
    // One word in the output stage, a full FIFO and one pending word
    check(n, `JBI_FIFO_DEPTH + 2);
    dr(8, 32'h0);
    check(q[1:0], 2'b00);
  endtask
  initial begin
    rst = 1'b1;
    trstN = 1'b1;
    configRequestN = 1'b1;
    cfgActive = 1'b0;
    cfgDone = 1'b0;
    chipClearN = 1'b1;
    chipOutputEnable = 1'b1;
    coreOut = 4'h0;
    coreOe = 4'h0;
    pinOutputOnly = 4'h0;
    pinIn = 4'h0;
    usrReady = 1'b0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    waitc(6);
    t_idcode();
    t_bypass();
    t_config();
    t_extest();
    t_inbuf();
    t_stream();
    results();
  end
endmodule
`default_nettype wire
